// ===== rtl/drdt_timer.v
`timescale 1ns/1ps
`include "drdt_map.vh"

// How it works
// R01 - Two timers, each an 8-bit down counter.
// R02 - Load bit copies reload register into counter.
// R03 - Run gates count clocks; stop keeps value.
// R04 - Low nibble read latches high nibble.
// R05 - Underflow reloads counter and keeps counting.
// R06 - Underflow drives flag, pulse output if selected, serial clock for timer 1 only.
// R07 - Event mode bit zero: timer 0 counts prescaler.
// R08 - Timer 1 counts prescaler clocks only.
// R09 - Event mode bit one: timer 0 counts pin edges.
// R10 - Event mode ignores prescaler and source selection.
// R11 - Polarity zero falling edge, one rising edge.
// R12 - Filter enable inserts noise rejector on input.
// R13 - Filtered change passes at second 2048 Hz fall.
// R14 - Source holds levels 0.98 ms; 0.48 ms rejected.
// R15 - Event mode otherwise behaves like timer mode.
// R16 - Prescaler divides by 1, 4, 32, 256.
// R17 - Source select zero OSC1, one OSC3.
// R18 - Underflow sets flag regardless of interrupt mask.
// R19 - Pulse output toggles on selected timer underflow.
// R20 - Load acts next edge; running continues from it.
module drdt_timer (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        osc1_tick,
  input  wire        osc3_tick,
  input  wire        event_input_pin,
  output wire        underflow_flag_t0,
  output wire        underflow_flag_t1,
  output reg         underflow_pulse_out,
  output wire        pulse_output_pin,
  output reg         serial_clk_out,
  output reg         uf_strobe_t0,
  output reg         uf_strobe_t1
);

  localparam [31:0] NR_LAST_FULL = `DRDT_NR_DIV - 1;
  localparam [3:0]  NR_LAST      = NR_LAST_FULL[3:0];

  // Bus timing in short: every read or write costs exactly one wait cycle.
  // The first cycle of a request raises waitrequest; the edge that ends it
  // captures read data and the counter nibble hold.
  // The second cycle shows waitrequest low, and the edge that ends it commits
  // a write and fires any load strobe.
  // A master that drops a write early leaves no trace, because writes
  // act only at the completing edge; a dropped read still updates readdata and the hold.

  // Maps a two-bit division code onto the prescaler terminal count.
  function [7:0] ps_last;
    input [1:0] code;
    begin
      case (code)
        2'h0:    ps_last = `DRDT_PS_LAST_1;
        2'h1:    ps_last = `DRDT_PS_LAST_4;
        2'h2:    ps_last = `DRDT_PS_LAST_32;
        default: ps_last = `DRDT_PS_LAST_256;
      endcase
    end
  endfunction

  // Word select of the register offsets, used by read and write decode.
  function hit;
    input [5:0] addr;
    input [5:0] ofs;
    begin
      hit = (addr[5:2] == ofs[5:2]);
    end
  endfunction

  reg  [`DRDT_CTRL_WIDTH-1:0] ctrl_r;
  reg  [7:0]                  reload_value_t0;
  reg  [7:0]                  reload_value_t1;
  reg  [1:0]                  flag_r;
  reg  [7:0]                  hold_r;
  reg                         ack_r;
  reg  [3:0]                  nr_div_r;
  reg  [1:0]                  nr_cnt_r;
  reg                         nr_level_r;
  reg                         ev_src_prev_r;
  wire                        acc_go;
  wire                        wr_go;
  wire                        rd_go;
  wire                        nr_tick;
  wire                        ev_src;
  wire                        ev_edge;
  wire [1:0]                  load_strobe;
  wire [1:0]                  uf;
  wire [15:0]                 cnt_all;
  wire                        event_mode_sel;
  wire                        event_edge_polarity;
  wire                        noise_filter_en;
  wire                        pulse_channel_sel;

  assign event_mode_sel      = ctrl_r[`DRDT_CTRL_EVMODE];
  assign event_edge_polarity = ctrl_r[`DRDT_CTRL_EVPOL];
  assign noise_filter_en     = ctrl_r[`DRDT_CTRL_NRF];
  assign pulse_channel_sel   = ctrl_r[`DRDT_CTRL_PULSE_CHANNEL_SEL];

  // Every access waits one cycle, then completes at the edge with waitrequest low.
  // Reads are captured in the wait cycle, writes at the completing edge.
  assign acc_go          = (avs_read | avs_write) & ack_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go           = avs_write & ack_r;
  assign rd_go           = avs_read & ~ack_r; // Read is captured in its wait cycle.

  // Load strobes fire at the completing edge of a write to the load register.
  assign load_strobe[0] = wr_go & hit(avs_address, `DRDT_OFS_LOAD) &
                          avs_byteenable[0] & avs_writedata[0]; // R02 R20
  assign load_strobe[1] = wr_go & hit(avs_address, `DRDT_OFS_LOAD) &
                          avs_byteenable[0] & avs_writedata[1]; // R02 R20

  // Handshake state: one wait cycle per request, cleared when it completes.
  always @(posedge mclk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r & ~acc_go;
    end
  end

  // Software writable registers take effect only at the completing edge.
  always @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_r          <= `DRDT_CTRL_RST;
      reload_value_t0 <= `DRDT_RELOAD_RST;
      reload_value_t1 <= `DRDT_RELOAD_RST;
    end else if (wr_go) begin
      if (hit(avs_address, `DRDT_OFS_CTRL)) begin
        if (avs_byteenable[0]) begin
          ctrl_r[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          ctrl_r[11:8] <= avs_writedata[11:8];
        end
      end
      if (hit(avs_address, `DRDT_OFS_RELOAD0) && avs_byteenable[0]) begin
        reload_value_t0 <= avs_writedata[7:0];
      end
      if (hit(avs_address, `DRDT_OFS_RELOAD1) && avs_byteenable[0]) begin
        reload_value_t1 <= avs_writedata[7:0];
      end
    end
  end

  // Underflow flags: hardware set beats a write-one clear in the same cycle.
  // A flag stays set until software writes one to it, so an underflow that
  // lands in the clearing cycle is never lost.
  always @(posedge mclk) begin
    if (sys_rst) begin
      flag_r <= 2'h0;
    end else begin
      if (wr_go && hit(avs_address, `DRDT_OFS_FLAGS) && avs_byteenable[0]) begin
        flag_r <= (flag_r & ~avs_writedata[1:0]) | uf; // R18
      end else begin
        flag_r <= flag_r | uf; // R18
      end
    end
  end

  assign underflow_flag_t0 = flag_r[0];
  assign underflow_flag_t1 = flag_r[1];

  // Reading a low nibble freezes that timer's high nibble for the next read.
  // The hold is taken at the same edge that captures the low nibble, so a
  // borrow between the two captures cannot split the pair.
  // Software must read the low nibble before the high one.
  always @(posedge mclk) begin
    if (sys_rst) begin
      hold_r <= 8'h00;
    end else if (rd_go) begin
      if (hit(avs_address, `DRDT_OFS_CNT0_LO)) begin
        hold_r[3:0] <= cnt_all[7:4]; // R04
      end
      if (hit(avs_address, `DRDT_OFS_CNT1_LO)) begin
        hold_r[7:4] <= cnt_all[15:12]; // R04
      end
    end
  end

  // Read data is registered in the wait cycle and stands at the completing edge.
  // Capturing here keeps readdata on flip-flops and lets it stand for the
  // whole completing cycle.
  always @(posedge mclk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata <= 32'h0000_0000;
      case (avs_address[5:2])
        `DRDT_OFS_CTRL >> 2:    avs_readdata[11:0] <= ctrl_r;
        `DRDT_OFS_RELOAD0 >> 2: avs_readdata[7:0]  <= reload_value_t0;
        `DRDT_OFS_RELOAD1 >> 2: avs_readdata[7:0]  <= reload_value_t1;
        `DRDT_OFS_CNT0_LO >> 2: avs_readdata[3:0]  <= cnt_all[3:0];
        `DRDT_OFS_CNT0_HI >> 2: avs_readdata[3:0]  <= hold_r[3:0];   // R04
        `DRDT_OFS_CNT1_LO >> 2: avs_readdata[3:0]  <= cnt_all[11:8];
        `DRDT_OFS_CNT1_HI >> 2: avs_readdata[3:0]  <= hold_r[7:4];   // R04
        `DRDT_OFS_FLAGS >> 2:   avs_readdata[1:0]  <= flag_r;
        default:                avs_readdata       <= 32'h0000_0000;
      endcase
    end
  end

  // The 2048 Hz sample tick is OSC1 divided by sixteen, one pulse per fall.
  always @(posedge mclk) begin
    if (sys_rst) begin
      nr_div_r <= 4'h0;
    end else if (osc1_tick) begin
      nr_div_r <= (nr_div_r == NR_LAST) ? 4'h0 : nr_div_r + 4'h1;
    end
  end

  assign nr_tick = osc1_tick & (nr_div_r == NR_LAST);

  // Noise rejector: a new level passes only after two sample ticks in a row.
  // The count restarts whenever the pin returns to the adopted level, so a
  // pulse shorter than one sample period never passes, while a level held
  // for two full periods always does.
  // The rejector runs even when disabled so its level is current when enabled.
  always @(posedge mclk) begin
    if (sys_rst) begin
      nr_level_r <= 1'b0;
      nr_cnt_r   <= 2'h0;
    end else if (event_input_pin == nr_level_r) begin
      nr_cnt_r <= 2'h0; // R14
    end else if (nr_tick) begin
      if (nr_cnt_r + 2'h1 == `DRDT_NR_TICKS) begin
        nr_level_r <= event_input_pin; // R13
        nr_cnt_r   <= 2'h0;
      end else begin
        nr_cnt_r <= nr_cnt_r + 2'h1;
      end
    end
  end

  // Edge detection on the raw or filtered event input.
  // The edge register resets to the idle low level of the pin, so no false
  // edge follows reset. Changing the filter while the pin and the
  // filtered level differ can produce one count; set it while stopped.
  assign ev_src = noise_filter_en ? nr_level_r : event_input_pin; // R12
  always @(posedge mclk) begin
    if (sys_rst) begin
      ev_src_prev_r <= 1'b0;
    end else begin
      ev_src_prev_r <= ev_src;
    end
  end

  assign ev_edge = event_edge_polarity ? (ev_src & ~ev_src_prev_r)  // R11
                                       : (~ev_src & ev_src_prev_r); // R11

  // One prescaler and down counter per timer.
  // Both channels share one structure; only timer 0 sees the event path.
  // A load and a count in the same cycle resolve in favour of the load, and
  // a counter clocked at zero reloads instead of wrapping to all ones.
  // The prescaler keeps its phase while stopped, so run and stop cost no ticks.
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_tmr
      reg  [7:0] ps_r;
      reg  [7:0] cnt_r;
      wire       run;
      wire       src_tick;
      wire       ps_tick;
      wire       cnt_tick;
      wire [7:0] reload;
      wire [1:0] ps_code;

      assign run     = ctrl_r[`DRDT_CTRL_RUN0 + i];
      assign ps_code = ctrl_r[`DRDT_CTRL_PS0_LO + 2*i +: 2];
      assign reload  = (i == 0) ? reload_value_t0 : reload_value_t1;
      assign src_tick = ctrl_r[`DRDT_CTRL_SOURCE_CLK_SEL_T0 + i] ? osc3_tick : osc1_tick; // R17

      // Prescaler divides the selected source while the timer runs.
      always @(posedge mclk) begin
        if (sys_rst) begin
          ps_r <= 8'h00;
        end else if (!run) begin
          ps_r <= ps_r; // R03
        end else if (src_tick) begin
          ps_r <= (ps_r >= ps_last(ps_code)) ? 8'h00 : ps_r + 8'h01; // R16
        end
      end

      assign ps_tick = run & src_tick & (ps_r >= ps_last(ps_code)); // R16

      // Timer 1 has no event path; timer 0 chooses by mode bit.
      if (i == 0) begin : g_src
        assign cnt_tick = event_mode_sel ? (run & ev_edge) // R09 R10 R15
                                         : ps_tick;        // R07
      end else begin : g_src
        assign cnt_tick = ps_tick; // R08
      end

      // Down counter: load wins, else count, reload when clocked at zero.
      always @(posedge mclk) begin
        if (sys_rst) begin
          cnt_r <= `DRDT_CNT_RST;
        end else if (load_strobe[i]) begin
          cnt_r <= reload; // R02 R20
        end else if (cnt_tick) begin
          cnt_r <= (cnt_r == 8'h00) ? reload : cnt_r - 8'h01; // R01 R05
        end
      end

      assign uf[i] = cnt_tick & ~load_strobe[i] & (cnt_r == 8'h00); // R05
      assign cnt_all[8*i +: 8] = cnt_r;
    end
  endgenerate

  // Underflow strobes, halved pulse output and the serial clock.
  // The strobes are registered so that they line up with the flags, which
  // are set at the same edge. The serial clock and pulse output run at half
  // the underflow rate of their timer.
  always @(posedge mclk) begin
    if (sys_rst) begin
      uf_strobe_t0        <= 1'b0;
      uf_strobe_t1        <= 1'b0;
      underflow_pulse_out <= 1'b0;
      serial_clk_out      <= 1'b0;
    end else begin
      uf_strobe_t0 <= uf[0]; // R06
      uf_strobe_t1 <= uf[1]; // R06
      if (uf[pulse_channel_sel]) begin
        underflow_pulse_out <= ~underflow_pulse_out; // R19
      end
      if (uf[1]) begin
        serial_clk_out <= ~serial_clk_out; // R06
      end
    end
  end

  assign pulse_output_pin = underflow_pulse_out;

endmodule

// ===== rtl/drdt_map.vh
`ifndef DRDT_MAP_VH
`define DRDT_MAP_VH

// Register byte offsets on the Avalon-MM slave, one 32-bit word each.
`define DRDT_OFS_CTRL     6'h00
`define DRDT_OFS_LOAD     6'h04
`define DRDT_OFS_RELOAD0  6'h08
`define DRDT_OFS_RELOAD1  6'h0c
`define DRDT_OFS_CNT0_LO  6'h10
`define DRDT_OFS_CNT0_HI  6'h14
`define DRDT_OFS_CNT1_LO  6'h18
`define DRDT_OFS_CNT1_HI  6'h1c
`define DRDT_OFS_FLAGS    6'h20

// Control register field positions.
`define DRDT_CTRL_RUN0    0
`define DRDT_CTRL_RUN1    1
`define DRDT_CTRL_EVMODE  2
`define DRDT_CTRL_EVPOL   3
`define DRDT_CTRL_NRF     4
`define DRDT_CTRL_SOURCE_CLK_SEL_T0  5
`define DRDT_CTRL_CKSEL1  6
`define DRDT_CTRL_PULSE_CHANNEL_SEL   7
`define DRDT_CTRL_PS0_LO  8
`define DRDT_CTRL_PS1_LO  10
`define DRDT_CTRL_WIDTH   12

// Reset values.
`define DRDT_CTRL_RST     12'h000
`define DRDT_RELOAD_RST   8'h00
`define DRDT_CNT_RST      8'h00

// Prescaler terminal counts for the division ratios 1, 4, 32 and 256.
`define DRDT_PS_LAST_1    8'h00
`define DRDT_PS_LAST_4    8'h03
`define DRDT_PS_LAST_32   8'h1f
`define DRDT_PS_LAST_256  8'hff

// Noise rejector timing: OSC1 rate, internal sample rate and ticks to pass.
`define DRDT_OSC1_HZ      32768
`define DRDT_NR_HZ        2048
`define DRDT_NR_DIV       (`DRDT_OSC1_HZ / `DRDT_NR_HZ)
`define DRDT_NR_TICKS     2'h2

`endif

// ===== verif/drdt_asserts.sv
`timescale 1ns/1ps
module drdt_checker (
  input wire mclk,
  input wire sys_rst,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire underflow_flag_t0,
  input wire underflow_flag_t1,
  input wire underflow_pulse_out,
  input wire pulse_output_pin,
  input wire serial_clk_out,
  input wire uf_strobe_t0,
  input wire uf_strobe_t1
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // A request that was idle one cycle before, and its single-wait completion.
  sequence s_req_new;
    (avs_read || avs_write) && !$past(avs_read || avs_write);
  endsequence
  sequence s_req_done;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  a_req_waits: assert property (s_req_new |-> avs_waitrequest) else $error("no wait state");
  a_one_wait: assert property (s_req_new |=> s_req_done) else $error("wait not one cycle");
  a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait while idle");
  a_flag0_set: assert property (uf_strobe_t0 |-> underflow_flag_t0) else $error("flag0");
  a_flag1_set: assert property (uf_strobe_t1 |-> underflow_flag_t1) else $error("flag1");
  a_flag0_cause: assert property ($rose(underflow_flag_t0) |-> uf_strobe_t0)
    else $error("flag0 without underflow");
  a_pin_mirror: assert property (pulse_output_pin == underflow_pulse_out)
    else $error("pin differs");
  a_pulse_cause: assert property ($changed(underflow_pulse_out) |-> (uf_strobe_t0 || uf_strobe_t1))
    else $error("pulse toggled alone");
  a_serial_div: assert property ($changed(serial_clk_out) == uf_strobe_t1)
    else $error("serial clock");
  a_strobe_once: assert property (uf_strobe_t0 |=> !uf_strobe_t0) else $error("strobe");
endmodule
bind drdt_timer drdt_checker u_chk (.mclk(mclk), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .underflow_flag_t0(underflow_flag_t0), .underflow_flag_t1(underflow_flag_t1),
  .underflow_pulse_out(underflow_pulse_out), .pulse_output_pin(pulse_output_pin),
  .serial_clk_out(serial_clk_out), .uf_strobe_t0(uf_strobe_t0), .uf_strobe_t1(uf_strobe_t1));

// ===== verif/drdt_event_src.sv
`timescale 1ns/1ps
module drdt_event_src (
  input  wire mclk,
  output reg  event_input_pin
);
  initial event_input_pin = 1'b0;
  // Drives one level and holds it; short holds stand for chatter.
  task automatic drive(input logic lvl, input int cycles);
    @(posedge mclk);
    event_input_pin <= lvl;
    repeat (cycles) @(posedge mclk);
  endtask
endmodule

// ===== verif/test_dual_reload_down_timer.sv
`timescale 1ns/1ps
`include "drdt_map.vh"
module test_dual_reload_down_timer;
  reg         mclk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [5:0]  avs_address = 6'h00;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg         osc1_tick = 1'b0;
  reg         osc3_tick = 1'b0;
  reg  [2:0]  c1 = 3'h0;
  reg  [1:0]  c3 = 2'h0;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, pin, f0, f1, pulse, pout, sclk, s0, s1;
  int         num_errors = 0;
  int         total_checks = 0;
  int         g, c;
  logic       p;
  logic       sc;
  int         ratio [4] = '{1, 4, 32, 256};
  drdt_timer DUT (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .osc1_tick(osc1_tick), .osc3_tick(osc3_tick), .event_input_pin(pin),
    .underflow_flag_t0(f0), .underflow_flag_t1(f1), .underflow_pulse_out(pulse),
    .pulse_output_pin(pout), .serial_clk_out(sclk), .uf_strobe_t0(s0), .uf_strobe_t1(s1));
  drdt_event_src src (.mclk(mclk), .event_input_pin(pin));
  initial begin
    forever #50 mclk = ~mclk;
  end
  // Source ticks: OSC1 every 8 cycles, OSC3 every 3 cycles.
  always @(posedge mclk) begin
    c1 <= c1 + 3'h1;
    c3 <= (c3 == 2'h2) ? 2'h0 : c3 + 2'h1;
    osc1_tick <= (c1 == 3'h7);
    osc3_tick <= (c3 == 2'h2);
  end
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus cycle; waitrequest is sampled at each rising edge while the request stands.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 40) begin
      num_errors++;
      test_done;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  // Cycles between two underflow strobes of one timer, bounded.
  task automatic gap_of(input bit t, output int gp);
    int n;
    for (n = 0; n < 20000 && (t ? s1 : s0) !== 1'b1; n++) @(negedge mclk);
    gp = 0;
    do begin
      @(negedge mclk);
      gp++;
    end while ((t ? s1 : s0) !== 1'b1 && gp < 20000);
    if (gp >= 20000) begin
      num_errors++;
      test_done;
    end
  endtask
  // Main sequence: reset, load and latch, prescaler, outputs, event counting.
  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd_chk(`DRDT_OFS_CTRL, 32'h0);
    wr(6'h3c, 32'hff);
    rd_chk(6'h3c, 32'h0);
    wr(`DRDT_OFS_RELOAD0, 32'h5a);
    wr(`DRDT_OFS_LOAD, 32'h1);
    rd_chk(`DRDT_OFS_CNT0_LO, 32'ha);
    rd_chk(`DRDT_OFS_CNT0_HI, 32'h5);
    rd_chk(`DRDT_OFS_LOAD, 32'h0);
    $display("test load done");
    wr(`DRDT_OFS_RELOAD0, 32'h1);
    for (c = 0; c < 4; c++) begin
      wr(`DRDT_OFS_CTRL, 32'h1 | (c << 8));
      gap_of(1'b0, g);
      gap_of(1'b0, g);
      check(g, 2 * ratio[c] * 8);
    end
    wr(`DRDT_OFS_RELOAD1, 32'h3);
    wr(`DRDT_OFS_LOAD, 32'h2);
    for (c = 0; c < 2; c++) begin
      wr(`DRDT_OFS_CTRL, 32'h442 | (c << 7));
      gap_of(1'b1, g);
      check(g, 4 * 4 * 3);
      p = pulse;
      sc = sclk;
      gap_of(1'b1, g);
      check(pulse, p ^ (c == 1));
      check(pout, p ^ (c == 1));
      check(sclk, sc ^ 1'b1);
    end
    rd_chk(`DRDT_OFS_FLAGS, 32'h3);
    wr(`DRDT_OFS_FLAGS, 32'h1);
    rd_chk(`DRDT_OFS_FLAGS, 32'h2);
    check({f1, f0}, 2'h2);
    $display("test prescaler done");
    wr(`DRDT_OFS_CTRL, 32'h02d);
    wr(`DRDT_OFS_RELOAD0, 32'h5);
    wr(`DRDT_OFS_LOAD, 32'h1);
    src.drive(1'b1, 6);
    src.drive(1'b0, 6);
    rd_chk(`DRDT_OFS_CNT0_LO, 32'h4);
    wr(`DRDT_OFS_CTRL, 32'h025);
    src.drive(1'b1, 6);
    rd_chk(`DRDT_OFS_CNT0_LO, 32'h4);
    src.drive(1'b0, 6);
    rd_chk(`DRDT_OFS_CNT0_LO, 32'h3);
    wr(`DRDT_OFS_CTRL, 32'h024);
    src.drive(1'b1, 6);
    src.drive(1'b0, 6);
    rd_chk(`DRDT_OFS_CNT0_LO, 32'h3);
    wr(`DRDT_OFS_CTRL, 32'h035);
    src.drive(1'b1, 3);
    src.drive(1'b0, 300);
    rd_chk(`DRDT_OFS_CNT0_LO, 32'h3);
    src.drive(1'b1, 300);
    src.drive(1'b0, 300);
    rd_chk(`DRDT_OFS_CNT0_LO, 32'h2);
    $display("test event done");
    test_done;
  end
endmodule
